// [hdl/adc_conversion_control.sv]
// Operation
// - High result byte read clears both flags
// - Free-run setup changes wait until free-run is cleared
// - One extra measurement after free-run cleared
// - Enable low stops conversions at once
// - Window wake from standby holds converter disabled
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_cfg.svh"

module adc_conversion_control (
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_arst_n,
    input  wire logic                       i_enable,
    input  wire logic                       i_free_running_bit,
    input  wire logic                       i_start,
    input  wire logic                       i_event_start_input,
    input  wire logic                       i_event,
    input  wire logic                       i_init_delay_en,
    input  wire adc_ctl_pkg::conv_setup_t   i_setup,
    input  wire logic [9:0]                 i_sample,
    input  wire logic                       i_read_result_high_byte,
    input  wire logic                       i_clear_result_ready,
    input  wire logic                       i_clear_window_compare,
    input  wire logic                       i_standby,
    input  wire logic                       i_wake,
    output logic                            o_busy,
    output logic                            o_ready,
    output adc_ctl_pkg::adc_flags_t         o_flags,
    output logic [9:0]                      o_result,
    output adc_ctl_pkg::conv_setup_t        o_active_setup
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_n;
    logic rst_n;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencing
    // ------------------------------------------------------------
    adc_ctl_pkg::conv_state_t state;
    adc_ctl_pkg::conv_state_t next_state;
    logic                     free_run_armed;
    logic                     wake_pending;
    logic                     cnt_load;
    logic [7:0]               cnt_value;
    logic                     cnt_done;
    logic                     start_req;
    logic                     window_hit;

    assign start_req = i_start || (i_event_start_input && i_event);
    assign window_hit = (i_sample < o_active_setup.window_low_threshold)
                     || (i_sample > o_active_setup.window_high_threshold);

    adc_down_counter u_counter (
        .i_clk   (i_clk_sys),
        .i_rst_n (rst_n),
        .i_load  (cnt_load),
        .i_value (cnt_value),
        .i_clear (!i_enable),
        .o_done  (cnt_done)
    );

    always_comb begin
        next_state = state;
        cnt_load   = 1'b0;
        cnt_value  = `CONV_CYCLES;
        case (state)
            adc_ctl_pkg::ST_OFF: begin
                if (i_enable) begin
                    next_state = adc_ctl_pkg::ST_INIT;
                    cnt_load   = 1'b1;
                    cnt_value  = `INIT_DELAY_CYCLES;
                end
            end
            adc_ctl_pkg::ST_INIT: begin
                if (cnt_done) begin
                    next_state = adc_ctl_pkg::ST_IDLE;
                end
            end
            adc_ctl_pkg::ST_IDLE: begin
                if (start_req || i_free_running_bit) begin
                    next_state = adc_ctl_pkg::ST_CONVERT;
                    cnt_load   = 1'b1;
                end
            end
            adc_ctl_pkg::ST_CONVERT: begin
                // Free-run sampled at start, so a late clear still gets one more run
                if (cnt_done && free_run_armed) begin
                    cnt_load = 1'b1;
                end else if (cnt_done) begin
                    next_state = adc_ctl_pkg::ST_IDLE;
                end
            end
            adc_ctl_pkg::ST_WAKE_HOLD: begin
                if (cnt_done) begin
                    next_state = i_init_delay_en ? adc_ctl_pkg::ST_INIT
                                                 : adc_ctl_pkg::ST_IDLE;
                    cnt_load   = i_init_delay_en;
                    cnt_value  = `INIT_DELAY_CYCLES;
                end
            end
            default: begin
                next_state = adc_ctl_pkg::ST_OFF;
            end
        endcase
        if (!i_enable) begin
            next_state = adc_ctl_pkg::ST_OFF;
            cnt_load   = 1'b0;
        end else if (wake_pending && state != adc_ctl_pkg::ST_WAKE_HOLD) begin
            next_state = adc_ctl_pkg::ST_WAKE_HOLD;
            cnt_load   = 1'b1;
            cnt_value  = `WAKE_HOLD_CYCLES;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= adc_ctl_pkg::ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // Free-run request is only looked at when a conversion is launched
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            free_run_armed <= 1'b0;
        end else if (cnt_load && next_state == adc_ctl_pkg::ST_CONVERT) begin
            free_run_armed <= i_free_running_bit;
        end else if (!i_enable) begin
            free_run_armed <= 1'b0;
        end
    end

    // Setup tracks input outside conversion while free-run is off; changes mid free-run land late
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_active_setup <= '0;
        end else if (state != adc_ctl_pkg::ST_CONVERT && !i_free_running_bit) begin
            o_active_setup <= i_setup;
        end
    end

    // Wake by window compare while in standby
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wake_pending <= 1'b0;
        end else if (i_standby && i_wake && o_flags.window_compare_flag) begin
            wake_pending <= 1'b1;
        end else if (state == adc_ctl_pkg::ST_WAKE_HOLD) begin
            wake_pending <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Result and flags
    // ------------------------------------------------------------
    logic conv_end;
    assign conv_end = (state == adc_ctl_pkg::ST_CONVERT) && cnt_done && i_enable;

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_result <= '0;
        end else if (conv_end) begin
            o_result <= i_sample;
        end
    end

    // Set wins over clear in the same cycle
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_flags <= '0;
        end else begin
            if (conv_end) begin
                o_flags.result_ready_flag <= 1'b1;
            end else if (i_read_result_high_byte || i_clear_result_ready) begin
                o_flags.result_ready_flag <= 1'b0;
            end
            if (conv_end && window_hit) begin
                o_flags.window_compare_flag <= 1'b1;
            end else if (i_read_result_high_byte || i_clear_window_compare) begin
                o_flags.window_compare_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_busy  <= 1'b0;
            o_ready <= 1'b0;
        end else begin
            o_busy  <= (next_state == adc_ctl_pkg::ST_CONVERT);
            o_ready <= (next_state == adc_ctl_pkg::ST_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_READ_CLEARS: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        (i_read_result_high_byte && !conv_end) |=> !o_flags.result_ready_flag
            && !o_flags.window_compare_flag)
        else $error("high byte read did not clear flags");

    AST_DISABLE_STOPS: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        !i_enable |=> state == adc_ctl_pkg::ST_OFF && !o_busy)
        else $error("disable did not stop conversion");

    AST_FREE_RUN_RESTART: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        (conv_end && free_run_armed && !wake_pending) |=> state == adc_ctl_pkg::ST_CONVERT)
        else $error("free run did not restart");

    AST_EXTRA_MEASURE: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        (conv_end && !free_run_armed && !start_req) |=> state != adc_ctl_pkg::ST_CONVERT)
        else $error("conversion continued after free run ended");

    // Repetition count tracks the wake hold count
    AST_WAKE_HOLD: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n || !i_enable)
        (state != adc_ctl_pkg::ST_WAKE_HOLD && next_state == adc_ctl_pkg::ST_WAKE_HOLD)
            |=> (state == adc_ctl_pkg::ST_WAKE_HOLD && !o_busy && !o_ready)[*4])
        else $error("wake hold not kept for its cycles");

    AST_SETUP_FROZEN: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        (state == adc_ctl_pkg::ST_CONVERT) |=> $stable(o_active_setup))
        else $error("setup changed mid conversion");

endmodule
`default_nettype wire

// [hdl/adc_ctl_cfg.svh]
`ifndef ADC_CTL_CFG_SVH
`define ADC_CTL_CFG_SVH

// Conversion timing in peripheral clock cycles
`define CONV_CYCLES        8'h0C
`define INIT_DELAY_CYCLES  8'h08
`define WAKE_HOLD_CYCLES   8'h04
`define RESULT_WIDTH       10
`define COUNT_ZERO         8'h00
`define COUNT_ONE          8'h01
`define SAMPLE_LEN_ZERO    4'h0

`endif

// [hdl/adc_ctl_pkg.sv]
package adc_ctl_pkg;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_INIT,
        ST_IDLE,
        ST_CONVERT,
        ST_WAKE_HOLD
    } conv_state_t;

    // Measurement setup latched outside conversion while free-run is off
    typedef struct packed {
        logic [7:0] second_control_register;
        logic [7:0] third_control_register;
        logic [7:0] sample_control_register;
        logic [4:0] input_channel_select;
        logic [9:0] window_low_threshold;
        logic [9:0] window_high_threshold;
    } conv_setup_t;

    typedef struct packed {
        logic result_ready_flag;
        logic window_compare_flag;
    } adc_flags_t;

endpackage

// [hdl/adc_down_counter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_cfg.svh"

module adc_down_counter (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_load,
    input  wire logic [7:0] i_value,
    input  wire logic       i_clear,
    output logic            o_done
);
    logic [7:0] count;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count <= `COUNT_ZERO;
        end else if (i_clear) begin
            count <= `COUNT_ZERO;
        end else if (i_load) begin
            count <= i_value;
        end else if (count != `COUNT_ZERO) begin
            count <= count - `COUNT_ONE;
        end
    end

    assign o_done = (count == `COUNT_ONE);

endmodule
`default_nettype wire

// [tb/adc_analog_model.sv]
`timescale 1ns/1ps
`default_nettype none

module adc_analog_model (
    input  wire logic                     i_clk_sys,
    input  wire adc_ctl_pkg::conv_setup_t i_active_setup,
    output logic [9:0]                    o_sample
);
    // ------------------------------------------------------------
    // Channel level
    // ------------------------------------------------------------
    // Follows the setup actually in use, so a late setup edit shows up
    always_ff @(posedge i_clk_sys) begin
        o_sample <= {i_active_setup.input_channel_select, 5'h0A};
    end
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk = 1'b0, arst_n = 1'b0, en = 1'b0, free = 1'b0, start = 1'b0;
    logic evs = 1'b0, ev = 1'b0, idly = 1'b0, rd_hi = 1'b0, clr_rr = 1'b0;
    logic clr_wc = 1'b0, stby = 1'b0, wake = 1'b0, busy, ready;
    logic [9:0] sample, result;
    int errors = 0, num_checks = 0, cycles = 0;
    adc_ctl_pkg::conv_setup_t setup, act;
    adc_ctl_pkg::adc_flags_t  flags;

    always #5 clk = ~clk;

    adc_conversion_control adc_conversion_control_i (
        .i_clk_sys(clk), .i_arst_n(arst_n), .i_enable(en), .i_free_running_bit(free),
        .i_start(start), .i_event_start_input(evs), .i_event(ev), .i_init_delay_en(idly),
        .i_setup(setup), .i_sample(sample), .i_read_result_high_byte(rd_hi),
        .i_clear_result_ready(clr_rr), .i_clear_window_compare(clr_wc), .i_standby(stby),
        .i_wake(wake), .o_busy(busy), .o_ready(ready), .o_flags(flags), .o_result(result),
        .o_active_setup(act));

    adc_analog_model adc_analog_model_i (.i_clk_sys(clk), .i_active_setup(act), .o_sample(sample));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic adc_ctl_pkg::conv_setup_t mk(input logic [4:0] ch, input logic [9:0] hi);
        mk = '0;
        mk.sample_control_register = 8'h00;
        mk.input_channel_select = ch;
        mk.window_high_threshold = hi;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s got %b", $time, what, got);
        end
    endtask

    task automatic chk10(input logic [9:0] got, input logic [9:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t result %h expected %h", $time, got, exp);
        end
    endtask

    // Bounded waits: a hang is reported by the following compare
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
    endtask

    task automatic wait_result();
        int n;
        n = 0;
        while (flags.result_ready_flag !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
    endtask

    task automatic read_hi();
        rd_hi = 1'b1;
        tick(1);
        rd_hi = 1'b0;
        tick(1);
    endtask

    task automatic convert(input logic [4:0] ch, input logic wc);
        start = 1'b1;
        tick(1);
        start = 1'b0;
        wait_result();
        chk10(result, {ch, 5'h0A});
        chk1(flags.window_compare_flag, wc, "window flag");
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Ceiling well above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            $display("[ERR] %0t timeout", $time);
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        setup = mk(5'h03, 10'h3FF);
        tick(4);
        arst_n = 1'b1;
        tick(3);
        en = 1'b1;
        wait_ready();
        convert(5'h03, 1'b0);
        read_hi();
        chk1(flags.result_ready_flag, 1'b0, "ready flag after read");
        $display("test single conversion done");
        setup = mk(5'h03, 10'h000);
        convert(5'h03, 1'b1);
        read_hi();
        chk1(flags.window_compare_flag, 1'b0, "window flag after read");
        convert(5'h03, 1'b1);
        clr_rr = 1'b1;
        clr_wc = 1'b1;
        tick(1);
        clr_rr = 1'b0;
        clr_wc = 1'b0;
        tick(1);
        chk1(flags.result_ready_flag, 1'b0, "direct clear");
        chk1(flags.window_compare_flag, 1'b0, "direct window clear");
        $display("test flag clearing done");
        // Setup lands only while free-run is off, so free-run goes on afterwards
        setup = mk(5'h03, 10'h3FF);
        tick(1);
        free = 1'b1;
        convert(5'h03, 1'b0);
        read_hi();
        setup = mk(5'h05, 10'h3FF);
        tick(1);
        chk1(act.input_channel_select === 5'h03, 1'b1, "setup held in free-run");
        wait_result();
        chk10(result, {5'h03, 5'h0A});
        free = 1'b0;
        read_hi();
        tick(30);
        wait_ready();
        chk1(ready, 1'b1, "stopped after one extra run");
        // The extra runs leave the result flag set; clear it before the next start
        read_hi();
        convert(5'h05, 1'b0);
        read_hi();
        $display("test free running done");
        free = 1'b1;
        start = 1'b1;
        tick(1);
        start = 1'b0;
        tick(3);
        en = 1'b0;
        tick(2);
        chk1(busy, 1'b0, "disable stops at once");
        free = 1'b0;
        en = 1'b1;
        wait_ready();
        $display("test disable done");
        setup = mk(5'h05, 10'h000);
        idly = 1'b1;
        convert(5'h05, 1'b1);
        stby = 1'b1;
        wake = 1'b1;
        tick(1);
        wake = 1'b0;
        tick(1);
        chk1(ready, 1'b0, "held after window wake");
        stby = 1'b0;
        tick(4);
        chk1(ready, 1'b0, "init delay after wake hold");
        wait_ready();
        chk1(ready, 1'b1, "ready after init delay");
        read_hi();
        $display("test window wake done");
        evs = 1'b1;
        ev = 1'b1;
        tick(1);
        ev = 1'b0;
        wait_result();
        chk1(flags.result_ready_flag, 1'b1, "event conversion");
        evs = 1'b0;
        wait_ready();
        chk1(busy, 1'b0, "event conversion drained");
        en = 1'b0;
        tick(2);
        $display("test event start done");
        conclude();
    end
endmodule
`default_nettype wire
